// [verilog/sub_acc_pkg.sv]
package sub_acc_pkg;

  // Instruction word layout.
  localparam int          INSN_W       = 14;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 7;
  localparam int          OPC_W        = 6;
  localparam int          OPC_LSB      = 8;
  localparam int          DEST_BIT     = 7;
  localparam logic [5:0]  OPC_SUB_ACC  = 6'h02;
  localparam logic [6:0]  ADDR_MAX     = 7'h7F;

  // Values after reset.
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic        FLAG_RESET   = 1'b0;

  // Destination select values.
  localparam logic        DEST_ACC     = 1'b0;
  localparam logic        DEST_REG     = 1'b1;

  // Decoded instruction fields.
  typedef struct packed {
    logic        hit;
    logic        dest;
    logic [6:0]  addr;
  } decode_s;

  // Status flags touched by the operation.
  typedef struct packed {
    logic carry;
    logic nibble_carry_flag;
    logic zero;
  } flags_s;

  // Arithmetic result bundle.
  typedef struct packed {
    logic [7:0] diff;
    flags_s     flags;
  } result_s;

  // Write request towards the file register space.
  typedef struct packed {
    logic        en;
    logic [6:0]  addr;
    logic [7:0]  data;
  } reg_wr_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } exec_state_e;

endpackage : sub_acc_pkg

// [verilog/sub_acc_alu.sv]
`timescale 1ns/1ps
module sub_acc_alu (
  // Operands
  input  wire logic [7:0]          reg_val_i,
  input  wire logic [7:0]          acc_val_i,
  // Result
  output sub_acc_pkg::result_s     result_o
);

  logic [8:0] full;
  logic [4:0] low;

  // Adding the inverted accumulator plus one makes carry mean no borrow.
  always_comb begin
    full = {1'b0, reg_val_i} + {1'b0, ~acc_val_i} + 9'h001;  // [RQ2]
    low  = {1'b0, reg_val_i[3:0]} + {1'b0, ~acc_val_i[3:0]} + 5'h01;
    result_o.diff                    = full[7:0];  // [RQ1]
    result_o.flags.carry             = full[8];  // [RQ7] [RQ8] [RQ9]
    result_o.flags.nibble_carry_flag = low[4];  // [RQ10]
    result_o.flags.zero              = (full[7:0] == 8'h00);  // [RQ10]
  end

endmodule : sub_acc_alu

// [verilog/subtract_w_from_file.sv]
`timescale 1ns/1ps
// Functional notes
// RQ1: Result is register value minus accumulator, sent to destination.
// RQ2: Eight-bit two's complement subtraction, wrapping modulo 256.
// RQ3: Decode 14-bit word 00_0010 d fffffff; bit 7 dest, bits 6..0 address.
// RQ4: Dest 0 writes accumulator, register left untouched.
// RQ5: Dest 1 writes register back, accumulator left untouched.
// RQ6: Address spans 0..127; destination is a single bit.
// RQ7: Carry set when register exceeds accumulator.
// RQ8: Carry set when register equals accumulator.
// RQ9: Carry cleared when accumulator exceeds register.
// RQ10: Zero flag from result; nibble carry set when no low-nibble borrow.
// RQ11: One word, one cycle; results visible to the next instruction.
module subtract_w_from_file (
  // Clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  // Instruction
  input  wire logic                    insn_valid_i,
  input  wire logic [13:0]             insn_i,
  // File register read port, combinational
  output logic      [6:0]              reg_rd_addr_o,
  input  wire logic [7:0]              reg_rd_data_i,
  // File register write port
  output sub_acc_pkg::reg_wr_s         reg_wr_o,
  // Accumulator and status
  output logic      [7:0]              acc_o,
  output sub_acc_pkg::flags_s          flags_o,
  output logic                         done_o
);

  // Decode.
  sub_acc_pkg::decode_s      dec;
  logic                      taken;
  logic                      to_acc;
  logic                      to_reg;

  // Operand path.
  logic                      fwd_hit;
  logic [7:0]                operand;
  sub_acc_pkg::result_s      res;

  // Architectural state and its next values.
  logic [7:0]                acc;
  logic [7:0]                next_acc;
  sub_acc_pkg::flags_s       flags;
  sub_acc_pkg::flags_s       next_flags;
  sub_acc_pkg::reg_wr_s      next_wr;
  logic                      next_done;

  // Sequencing.
  sub_acc_pkg::exec_state_e  state;
  sub_acc_pkg::exec_state_e  next_state;

  function automatic sub_acc_pkg::decode_s decode(
    input logic [13:0] w
  );
    sub_acc_pkg::decode_s d;
    d.hit  = (w[13:8] == sub_acc_pkg::OPC_SUB_ACC);  // [RQ3]
    d.dest = w[sub_acc_pkg::DEST_BIT];  // [RQ3] [RQ6]
    d.addr = w[6:0];  // [RQ6]
    return d;
  endfunction : decode

  function automatic logic same_addr(
    input logic [6:0] a,
    input logic [6:0] b
  );
    return (a == b);
  endfunction : same_addr

  function automatic logic goes_to(
    input sub_acc_pkg::decode_s d,
    input logic                 valid,
    input logic                 sel
  );
    return d.hit & valid & (d.dest == sel);
  endfunction : goes_to

  function automatic sub_acc_pkg::flags_s clear_flags();
    sub_acc_pkg::flags_s f;
    f.carry             = sub_acc_pkg::FLAG_RESET;
    f.nibble_carry_flag = sub_acc_pkg::FLAG_RESET;
    f.zero              = sub_acc_pkg::FLAG_RESET;
    return f;
  endfunction : clear_flags

  function automatic sub_acc_pkg::reg_wr_s idle_write();
    sub_acc_pkg::reg_wr_s r;
    r.en   = 1'b0;
    r.addr = 7'h00;
    r.data = 8'h00;
    return r;
  endfunction : idle_write

  always_comb begin
    dec    = decode(insn_i);
    taken  = dec.hit & insn_valid_i;  // [RQ3]
    to_acc = goes_to(dec, insn_valid_i, sub_acc_pkg::DEST_ACC);  // [RQ4]
    to_reg = goes_to(dec, insn_valid_i, sub_acc_pkg::DEST_REG);  // [RQ5]
  end

  // The read address follows the word directly so the operand is ready.
  always_comb begin
    reg_rd_addr_o = dec.addr;  // [RQ6]
  end

  // The file takes a write one cycle late, so a word that reads the register
  // written just before takes the pending data rather than the stale copy.
  always_comb begin
    fwd_hit = (state == sub_acc_pkg::ST_EXEC) && reg_wr_o.en &&
              same_addr(reg_wr_o.addr, dec.addr);  // [RQ11]
    if (fwd_hit) begin
      operand = reg_wr_o.data;  // [RQ11]
    end else begin
      operand = reg_rd_data_i;  // [RQ1]
    end
  end

  sub_acc_alu u_alu (
    .reg_val_i (operand),
    .acc_val_i (acc),
    .result_o  (res)
  );

  always_comb begin
    next_acc = acc;
    if (to_acc) begin
      next_acc = res.diff;  // [RQ1] [RQ2] [RQ4]
    end
  end

  always_comb begin
    next_flags = flags;
    if (taken) begin
      next_flags = res.flags;  // [RQ7] [RQ8] [RQ9] [RQ10]
    end
  end

  always_comb begin
    next_wr = idle_write();
    if (to_reg) begin
      next_wr.en   = 1'b1;  // [RQ5]
      next_wr.addr = dec.addr;  // [RQ5] [RQ6]
      next_wr.data = res.diff;  // [RQ1] [RQ2]
    end
  end

  // ST_EXEC marks the cycle in which a result is shown and may be forwarded.
  always_comb begin
    case (state)
      sub_acc_pkg::ST_IDLE: begin
        if (taken) begin
          next_state = sub_acc_pkg::ST_EXEC;  // [RQ11]
        end else begin
          next_state = sub_acc_pkg::ST_IDLE;
        end
      end
      sub_acc_pkg::ST_EXEC: begin
        if (taken) begin
          next_state = sub_acc_pkg::ST_EXEC;  // [RQ11]
        end else begin
          next_state = sub_acc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sub_acc_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    next_done = (next_state == sub_acc_pkg::ST_EXEC);  // [RQ11]
  end

  // One edge commits every result, so the next word already sees it.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= sub_acc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      acc <= sub_acc_pkg::ACC_RESET;
    end else begin
      acc <= next_acc;  // [RQ4] [RQ11]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flags <= clear_flags();
    end else begin
      flags <= next_flags;  // [RQ11]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_wr_o <= idle_write();
    end else begin
      reg_wr_o <= next_wr;  // [RQ5]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= next_done;  // [RQ11]
    end
  end

  always_comb begin
    acc_o = acc;
  end

  always_comb begin
    flags_o = flags;
  end

endmodule : subtract_w_from_file

// [dv/sub_acc_props.sv]
`timescale 1ns/1ps
module sub_acc_props (
  // Watched ports
  input wire logic                 core_clk_i,
  input wire logic                 rst_i,
  input wire logic                 insn_valid_i,
  input wire logic [13:0]          insn_i,
  input wire logic [6:0]           reg_rd_addr_o,
  input wire logic [7:0]           reg_rd_data_i,
  input wire sub_acc_pkg::reg_wr_s reg_wr_o,
  input wire logic [7:0]           acc_o,
  input wire sub_acc_pkg::flags_s  flags_o,
  input wire logic                 done_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic       tk;
  logic       fw;
  logic       cy;
  logic       nc;
  logic [7:0] op;
  logic [7:0] df;
  assign tk = insn_valid_i && insn_i[13:8] == sub_acc_pkg::OPC_SUB_ACC;
  // A write still on its way to the file stands in for the stale read.
  assign fw = reg_wr_o.en && reg_wr_o.addr == insn_i[6:0];
  assign op = fw ? reg_wr_o.data : reg_rd_data_i;
  assign df = op - acc_o;
  assign cy = op >= acc_o;
  assign nc = op[3:0] >= acc_o[3:0];
  a_read_addr: assert property (reg_rd_addr_o == insn_i[6:0])
    else $error("bad address");
  a_done_pulse: assert property (tk |=> done_o)
    else $error("no done");
  a_refused_word: assert property (!tk |=> !done_o && !reg_wr_o.en)
    else $error("refused word acted");
  a_acc_dest: assert property (tk && !insn_i[7] |=>
    acc_o == $past(df) && !reg_wr_o.en) else $error("bad acc");
  a_reg_dest: assert property (tk && insn_i[7] |=>
    reg_wr_o == {1'b1, $past(reg_rd_addr_o), $past(df)} && $stable(acc_o))
    else $error("bad write");
  a_carry_flag: assert property (tk |=>
    flags_o.carry == $past(cy)) else $error("bad carry");
  a_zero_flag: assert property (tk |=>
    flags_o.zero == ($past(df) == 8'h00)) else $error("bad zero");
  a_nibble_flag: assert property (tk |=>
    flags_o.nibble_carry_flag == $past(nc)) else $error("bad nibble");
  a_idle_hold: assert property (!tk |=>
    $stable(acc_o) && $stable(flags_o)) else $error("state moved");
  c_to_reg: cover property (tk && insn_i[7]);
  c_to_acc: cover property (tk && !insn_i[7]);
  c_back: cover property (tk ##1 tk);
  c_forward: cover property (tk && fw);
endmodule : sub_acc_props
bind subtract_w_from_file sub_acc_props u_props (
  .core_clk_i    (core_clk_i),
  .rst_i         (rst_i),
  .insn_valid_i  (insn_valid_i),
  .insn_i        (insn_i),
  .reg_rd_addr_o (reg_rd_addr_o),
  .reg_rd_data_i (reg_rd_data_i),
  .reg_wr_o      (reg_wr_o),
  .acc_o         (acc_o),
  .flags_o       (flags_o),
  .done_o        (done_o)
);

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic                 core_clk_i = 0;
  logic                 rst_i = 1;
  logic                 insn_valid_i = 0;
  logic [13:0]          insn_i = 14'h0000;
  logic [7:0]           reg_rd_data_i = 8'h00;
  logic [7:0]           w = 8'h00;
  logic [7:0]           d;
  logic [7:0]           o;
  logic [15:0]          fw = 16'h0000;
  logic [6:0]           reg_rd_addr_o;
  sub_acc_pkg::reg_wr_s reg_wr_o;
  logic [7:0]           acc_o;
  sub_acc_pkg::flags_s  flags_o;
  logic                 done_o;
  logic [18:0]          q[$];
  logic [18:0]          e;
  int                   seed = 42, error_cnt = 0, checks = 0, cyc = 0, r;
  subtract_w_from_file u_dut (
    .core_clk_i    (core_clk_i),
    .rst_i         (rst_i),
    .insn_valid_i  (insn_valid_i),
    .insn_i        (insn_i),
    .reg_rd_addr_o (reg_rd_addr_o),
    .reg_rd_data_i (reg_rd_data_i),
    .reg_wr_o      (reg_wr_o),
    .acc_o         (acc_o),
    .flags_o       (flags_o),
    .done_o        (done_o)
  );
  initial forever #2.5 core_clk_i = ~core_clk_i;
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic cmp(string n, logic [15:0] x, logic [15:0] s);
    checks++;
    if (x !== s) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, x, s);
    end
  endtask : cmp
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  always @(negedge core_clk_i) if (done_o === 1'b1) begin
    e = q.size() ? q.pop_front() : 19'h7_FFFF;
    cmp("flags", 16'(e[2:0]), 16'(flags_o));
    if (e[18]) cmp("wr", {1'b1, e[17:3]}, reg_wr_o);
    else cmp("acc", 16'(e[10:3]), {7'h00, reg_wr_o.en, acc_o});
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    #1 rst_i = 0;
    repeat (2000) begin
      r = $random(seed);
      // Some words reuse the address just written, to exercise forwarding.
      insn_i = {(r[1:0] != 0 ? 6'h02 : r[13:8]), r[21],
                (r[7:6] == 0 ? fw[14:8] : r[20:14])};
      insn_valid_i = r[2] | r[3];
      // One word in four reuses the accumulator so equal operands occur.
      reg_rd_data_i = r[5:4] == 0 ? w : r[31:24];
      // A register written by the word before is forwarded, not read back.
      o = fw[15] && fw[14:8] == insn_i[6:0] ? fw[7:0] : reg_rd_data_i;
      d = o - w;
      fw = 16'h0000;
      if (insn_valid_i && insn_i[13:8] == 6'h02) begin
        q.push_back({insn_i[7:0], d, o >= w, o[3:0] >= w[3:0], d == 8'h00});
        if (!insn_i[7]) w = d;
        else fw = {1'b1, insn_i[6:0], d};
      end
      #1 cmp("rd_addr", 16'(insn_i[6:0]), 16'(reg_rd_addr_o));
      @(posedge core_clk_i);
      #1;
    end
    insn_valid_i = 0;
    repeat (3) @(posedge core_clk_i);
    checks++;
    if (q.size() != 0) begin
      error_cnt++;
      $display("[FAIL] pending exp 0 got %0d", q.size());
    end
    close_out();
  end
endmodule : testbench
